/* File: hw/ahip_top.v */
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ahip_defs.vh"
// Notes on behaviour
// [RL1] In serial mode the result-valid flag is low without postprocessor overflow and high once one occurs.
// [RL2] In parallel mode the attention output idles low and goes high when host action is needed.
// [RL3] Instruction completion raises attention; an instruction write or status read clears it.
// [RL4] A write-data request raises attention; a data write clears it.
// [RL5] Read data ready raises attention; a data read clears it.
// [RL6] ID mismatch, CRC failure or postprocessor overflow raise attention, cleared only by a status read.
// [RL7] Power-on reset completion raises attention, cleared by a status read.
// [RL8] In parallel mode read-write select high means read, low means write.
// [RL9] The host holds chip select low with the read-write level during any parallel access.
// [RL10] In serial mode the board ties read-write select to digital ground and the device ignores it.
// [RL11] Interface select low picks parallel, high picks serial.
// [RL12] Interface select is latched once after power-up; later changes do nothing.
// [RL13] Oscillator disable high takes the clock from the pin; low runs the crystal amplifier.
// [RL14] The clock source runs without interruption while powered; reset drives clk_from_pin_q and crystal_drive_pin_amp_en_q both low.
// [RL15] Register select high: status read or instruction write; low: data register.
// [RL16] Attention stays high until every pending cause has had its clearing access.
module ahip_top (
  input wire sys_clk,
  input wire rstn,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire irq,
  // host pins
  input wire cs_n,
  input wire rd_wr,
  input wire register_select,
  input wire serial_sel,
  input wire oscillator_disable,
  // outputs
  output wire attn_out,
  output wire result_valid_flag,
  output reg crystal_drive_pin_amp_en_q,
  output reg clk_from_pin_q,
  output reg serial_mode_q,
  output reg instr_wr_q,
  output reg status_rd_q,
  output reg data_wr_q,
  output reg data_rd_q
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire cs_n_s;
  wire rd_wr_s;
  wire rsel_s;
  wire ssel_s;
  wire xoff_s;
  ahip_sync3 u_s_cs (.sys_clk(sys_clk), .rstn(rstn), .din(~cs_n), .dout_q(cs_n_s));
  ahip_sync3 u_s_rw (.sys_clk(sys_clk), .rstn(rstn), .din(rd_wr), .dout_q(rd_wr_s));
  ahip_sync3 u_s_rs (.sys_clk(sys_clk), .rstn(rstn), .din(register_select), .dout_q(rsel_s));
  ahip_sync3 u_s_sp (.sys_clk(sys_clk), .rstn(rstn), .din(serial_sel), .dout_q(ssel_s));
  ahip_sync3 u_s_xo (.sys_clk(sys_clk), .rstn(rstn), .din(oscillator_disable), .dout_q(xoff_s));
  // cs_n_s is the active-high select after inversion
  wire cs_act = cs_n_s;

  // ----------------------------------------
  // mode latch after reset release
  // ----------------------------------------
  // sync pipe needs a few cycles to fill before sampling
  reg [2:0] boot_cnt_q;
  reg mode_locked_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      boot_cnt_q <= 3'h0;
      mode_locked_q <= 1'b0;
      serial_mode_q <= 1'b0;
      clk_from_pin_q <= 1'b0;
      crystal_drive_pin_amp_en_q <= 1'b0;
    end else begin
      if (!mode_locked_q) begin
        boot_cnt_q <= boot_cnt_q + 3'h1;
        if (boot_cnt_q == 3'h5) begin
          mode_locked_q <= 1'b1;
          serial_mode_q <= ssel_s; // RL11 RL12
        end
      end
      clk_from_pin_q <= xoff_s; // RL13
      crystal_drive_pin_amp_en_q <= ~xoff_s; // RL13
    end
  end
  wire par_mode = mode_locked_q & ~serial_mode_q; // RL11

  // ----------------------------------------
  // parallel access decode
  // ----------------------------------------
  // one strobe per access, on chip-select assertion; rd_wr ignored in serial mode
  reg cs_d1_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cs_d1_q <= 1'b0;
    end else begin
      cs_d1_q <= cs_act;
    end
  end
  wire acc = par_mode & cs_act & ~cs_d1_q; // RL9 RL10
  wire acc_rd = acc & rd_wr_s; // RL8
  wire acc_wr = acc & ~rd_wr_s; // RL8
  wire st_rd = acc_rd & rsel_s; // RL15
  wire in_wr = acc_wr & rsel_s; // RL15
  wire dt_rd = acc_rd & ~rsel_s; // RL15
  wire dt_wr = acc_wr & ~rsel_s; // RL15
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instr_wr_q <= 1'b0;
      status_rd_q <= 1'b0;
      data_wr_q <= 1'b0;
      data_rd_q <= 1'b0;
    end else begin
      instr_wr_q <= in_wr;
      status_rd_q <= st_rd;
      data_wr_q <= dt_wr;
      data_rd_q <= dt_rd;
    end
  end

  // ----------------------------------------
  // core event inputs from ctrl register
  // ----------------------------------------
  // software stands in for the core: writing a one to a ctrl bit pulses that event
  reg [6:0] ev_q;
  reg ovf_q;
  wire bus_wr;
  wire [3:0] bus_a = avs_address;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ev_q <= 7'h00;
      ovf_q <= 1'b0;
    end else begin
      ev_q <= 7'h00;
      if (bus_wr && bus_a == `AHIP_OFF_CTRL) begin
        ev_q <= avs_writedata[6:0];
        if (avs_writedata[`AHIP_CTRL_OVF]) begin
          ovf_q <= 1'b1;
        end else if (avs_writedata[7]) begin
          ovf_q <= 1'b0;
        end
      end
    end
  end
  // overflow level shown on result-valid flag in serial mode
  assign result_valid_flag = serial_mode_q & ovf_q; // RL1

  // ----------------------------------------
  // attention causes
  // ----------------------------------------
  wire [`AHIP_NEV-1:0] set_v;
  wire [`AHIP_NEV-1:0] clr_v;
  wire [`AHIP_NEV-1:0] pend;
  assign set_v[`AHIP_EV_DONE] = ev_q[`AHIP_CTRL_DONE]; // RL3
  assign clr_v[`AHIP_EV_DONE] = in_wr | st_rd; // RL3
  assign set_v[`AHIP_EV_WREQ] = ev_q[`AHIP_CTRL_WREQ]; // RL4
  assign clr_v[`AHIP_EV_WREQ] = dt_wr; // RL4
  assign set_v[`AHIP_EV_RDY] = ev_q[`AHIP_CTRL_RDY]; // RL5
  assign clr_v[`AHIP_EV_RDY] = dt_rd; // RL5
  assign set_v[`AHIP_EV_ERR] = ev_q[`AHIP_CTRL_IDERR] | ev_q[`AHIP_CTRL_CRCERR] | ev_q[`AHIP_CTRL_OVF]; // RL6
  assign clr_v[`AHIP_EV_ERR] = st_rd; // RL6
  assign set_v[`AHIP_EV_POR] = ev_q[`AHIP_CTRL_PORDONE]; // RL7
  assign clr_v[`AHIP_EV_POR] = st_rd; // RL7
  genvar gi;
  generate
    for (gi = 0; gi < `AHIP_NEV; gi = gi + 1) begin : g_cause
      ahip_attn u_c (.sys_clk(sys_clk), .rstn(rstn), .set(set_v[gi]), .clr(clr_v[gi]), .pend_q(pend[gi]));
    end
  endgenerate
  // in parallel mode any pending cause keeps the line up
  assign attn_out = par_mode & (|pend); // RL2 RL16

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  reg [`AHIP_NEV-1:0] sts_q;
  reg [`AHIP_NEV-1:0] mask_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sts_q <= `AHIP_STATUS_RST;
      mask_q <= `AHIP_MASK_RST;
    end else begin
      // set wins over write-one-to-clear
      if (bus_wr && bus_a == `AHIP_OFF_STATUS) begin
        sts_q <= (sts_q & ~avs_writedata[`AHIP_NEV-1:0]) | set_v;
      end else begin
        sts_q <= sts_q | set_v;
      end
      if (bus_wr && bus_a == `AHIP_OFF_MASK) begin
        mask_q <= avs_writedata[`AHIP_NEV-1:0];
      end
    end
  end
  assign irq = |(sts_q & mask_q);

  // ----------------------------------------
  // avalon slave: one wait cycle, answer on second edge
  // ----------------------------------------
  reg ack_q;
  wire req = avs_read | avs_write;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end
  assign avs_waitrequest = req & ~ack_q;
  assign bus_wr = avs_write & ack_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_q) begin
      case (bus_a)
        `AHIP_OFF_STATUS: avs_readdata <= {27'h0, sts_q};
        `AHIP_OFF_MASK: avs_readdata <= {27'h0, mask_q};
        `AHIP_OFF_CTRL: avs_readdata <= {31'h0, ovf_q};
        `AHIP_OFF_PINS: avs_readdata <= {22'h0, pend, mode_locked_q, serial_mode_q, clk_from_pin_q, attn_out, result_valid_flag};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: hw/ahip_defs.vh */
`ifndef AHIP_DEFS_VH
`define AHIP_DEFS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define AHIP_OFF_STATUS 4'h0
`define AHIP_OFF_MASK 4'h4
`define AHIP_OFF_CTRL 4'h8
`define AHIP_OFF_PINS 4'hc
// ----------------------------------------
// interrupt cause bit positions
// ----------------------------------------
`define AHIP_EV_DONE 0
`define AHIP_EV_WREQ 1
`define AHIP_EV_RDY 2
`define AHIP_EV_ERR 3
`define AHIP_EV_POR 4
`define AHIP_NEV 5
// ----------------------------------------
// ctrl register fields
// ----------------------------------------
`define AHIP_CTRL_DONE 0
`define AHIP_CTRL_WREQ 1
`define AHIP_CTRL_RDY 2
`define AHIP_CTRL_IDERR 3
`define AHIP_CTRL_CRCERR 4
`define AHIP_CTRL_OVF 5
`define AHIP_CTRL_PORDONE 6
// ----------------------------------------
// reset values
// ----------------------------------------
`define AHIP_MASK_RST 5'h00
`define AHIP_STATUS_RST 5'h00
`endif

/* File: hw/ahip_sync3.v */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output moves once stages two and three agree
module ahip_sync3 (
  input wire sys_clk,
  input wire rstn,
  input wire din,
  output reg dout_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/ahip_attn.v */
`timescale 1ns/1ps
`default_nettype none
// one pending cause: set wins over clear
module ahip_attn (
  input wire sys_clk,
  input wire rstn,
  input wire set,
  input wire clr,
  output reg pend_q
);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else if (set) begin
      pend_q <= 1'b1;
    end else if (clr) begin
      pend_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/ahip_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ahip_top_props (
  input wire sys_clk,
  input wire rstn,
  input wire rd_wr,
  input wire register_select,
  input wire oscillator_disable,
  input wire attn_out,
  input wire result_valid_flag,
  input wire crystal_drive_pin_amp_en_q,
  input wire clk_from_pin_q,
  input wire serial_mode_q,
  input wire instr_wr_q,
  input wire status_rd_q,
  input wire data_wr_q,
  input wire data_rd_q
);
  // ------------
  // checks
  // ------------
  wire any_acc = instr_wr_q | status_rd_q | data_wr_q | data_rd_q;
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  attn_serial_a: assert property (serial_mode_q |-> !attn_out)
    else $error("attention high in serial mode");
  valid_parallel_a: assert property (!serial_mode_q |-> !result_valid_flag)
    else $error("result valid high in parallel mode");
  // sync chain needs up to five edges to settle
  pin_clock_a: assert property (oscillator_disable [*6] |-> clk_from_pin_q && !crystal_drive_pin_amp_en_q)
    else $error("pin clock not selected");
  crystal_drive_pin_clock_a: assert property (!oscillator_disable [*6] |-> !clk_from_pin_q && crystal_drive_pin_amp_en_q)
    else $error("crystal amplifier not enabled");
  serial_quiet_a: assert property (any_acc |-> !serial_mode_q)
    else $error("host strobe in serial mode");
  read_decode_a: assert property ((status_rd_q | data_rd_q) |-> rd_wr && register_select == status_rd_q)
    else $error("read strobe decoded wrongly");
  write_decode_a: assert property ((instr_wr_q | data_wr_q) |-> !rd_wr && register_select == instr_wr_q)
    else $error("write strobe decoded wrongly");
  mode_lock_a: assert property (!$fell(serial_mode_q))
    else $error("mode changed while running");
  strobe_pulse_a: assert property (status_rd_q |=> !status_rd_q)
    else $error("status strobe longer than one cycle");
  cover property ($rose(attn_out));
  cover property ($rose(result_valid_flag));
  cover property (status_rd_q);
endmodule
bind ahip_top ahip_top_props u_props(.sys_clk(sys_clk), .rstn(rstn), .rd_wr(rd_wr),
  .register_select(register_select), .oscillator_disable(oscillator_disable), .attn_out(attn_out),
  .result_valid_flag(result_valid_flag), .crystal_drive_pin_amp_en_q(crystal_drive_pin_amp_en_q), .clk_from_pin_q(clk_from_pin_q),
  .serial_mode_q(serial_mode_q), .instr_wr_q(instr_wr_q), .status_rd_q(status_rd_q),
  .data_wr_q(data_wr_q), .data_rd_q(data_rd_q));
`default_nettype wire

/* File: tb/ahip_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ahip_host_model (
  input wire logic sys_clk,
  input wire logic serial,
  output logic cs_n,
  output logic rd_wr,
  output logic register_select
);
  initial begin
    cs_n = 1'b1;
    rd_wr = 1'b0;
    register_select = 1'b0;
  end
  // ------------
  // one access
  // ------------
  task automatic access(input logic rw, input logic rs);
    @(posedge sys_clk);
    rd_wr <= rw & ~serial;
    register_select <= rs;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cs_n <= 1'b1;
    // released pins must not keep the old level
    rd_wr <= ~rw & ~serial;
    register_select <= ~rs;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_ahip_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ahip_defs.vh"
module test_ahip_top;
  logic sys_clk, rstn, avs_read, avs_write, serial_sel, oscillator_disable;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, e;
  logic avs_waitrequest, irq, attn_out, result_valid_flag, cs_n, rd_wr, register_select;
  int mismatches, check_count, cyc;
  int ctl[8] = '{0, 0, 1, 2, 3, 4, 5, 6};
  int pnd[8] = '{0, 0, 1, 2, 3, 3, 3, 4};
  int bad[8] = '{0, 2, 3, 1, 1, 0, 2, 0};
  int good[8] = '{1, 3, 0, 2, 3, 3, 3, 3};
  ahip_top u_dut(.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .cs_n(cs_n), .rd_wr(rd_wr), .register_select(register_select),
    .serial_sel(serial_sel), .oscillator_disable(oscillator_disable), .attn_out(attn_out),
    .result_valid_flag(result_valid_flag), .crystal_drive_pin_amp_en_q(), .clk_from_pin_q(), .serial_mode_q(),
    .instr_wr_q(), .status_rd_q(), .data_wr_q(), .data_rd_q());
  ahip_host_model u_host(.sys_clk(sys_clk), .serial(serial_sel), .cs_n(cs_n), .rd_wr(rd_wr),
    .register_select(register_select));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ------------
  // tasks
  // ------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    // hold the request until waitrequest is seen low at a rising edge
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(rd & m, x);
  endtask
  task automatic ev(input int b);
    bus(1'b1, `AHIP_OFF_CTRL, 32'h1 << b);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic do_reset(input logic ser, input logic osc);
    rstn <= 1'b0;
    serial_sel <= ser;
    oscillator_disable <= osc;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask
  // ------------
  // tests
  // ------------
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = 0;
    {rstn, serial_sel, oscillator_disable, mismatches, check_count, cyc} = 0;
    do_reset(1'b0, 1'b1);
    rdchk(`AHIP_OFF_PINS, 32'h14, 32'hffffffff);
    ev(`AHIP_CTRL_DONE);
    rdchk(`AHIP_OFF_STATUS, 32'h1, 32'hffffffff);
    #1 chk({31'h0, irq}, 32'h0);
    bus(1'b1, `AHIP_OFF_MASK, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    bus(1'b1, `AHIP_OFF_STATUS, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    rdchk(4'h2, 32'h0, 32'hffffffff);
    u_host.access(1'b1, 1'b1);
    rdchk(`AHIP_OFF_PINS, 32'h14, 32'hffffffff);
    $display("interrupt test done");
    for (int i = 0; i < 8; i++) begin
      ev(ctl[i]);
      e = 32'h16 | (32'h20 << pnd[i]);
      rdchk(`AHIP_OFF_PINS, e, 32'hffffffff);
      chk({31'h0, attn_out}, 32'h1);
      u_host.access(bad[i][1], bad[i][0]);
      rdchk(`AHIP_OFF_PINS, e, 32'hffffffff);
      u_host.access(good[i][1], good[i][0]);
      rdchk(`AHIP_OFF_PINS, 32'h14, 32'hffffffff);
      chk({31'h0, attn_out}, 32'h0);
      $display("cause test %0d done", i);
    end
    ev(`AHIP_CTRL_DONE);
    ev(`AHIP_CTRL_RDY);
    u_host.access(1'b0, 1'b1);
    rdchk(`AHIP_OFF_PINS, 32'h96, 32'hffffffff);
    u_host.access(1'b1, 1'b0);
    rdchk(`AHIP_OFF_PINS, 32'h14, 32'hffffffff);
    $display("pending test done");
    do_reset(1'b1, 1'b0);
    rdchk(`AHIP_OFF_PINS, 32'h18, 32'h1f);
    ev(`AHIP_CTRL_OVF);
    rdchk(`AHIP_OFF_PINS, 32'h19, 32'h1f);
    chk({31'h0, result_valid_flag}, 32'h1);
    u_host.access(1'b1, 1'b1);
    serial_sel <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rdchk(`AHIP_OFF_PINS, 32'h19, 32'h1f);
    bus(1'b1, `AHIP_OFF_CTRL, 32'h80);
    rdchk(`AHIP_OFF_PINS, 32'h18, 32'h1f);
    chk({31'h0, result_valid_flag}, 32'h0);
    $display("serial test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
